//--- logic/ues_params.svh
// Offsets, field positions, reset values and timing counts
`ifndef UES_PARAMS_SVH
`define UES_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define UES_CLK_MHZ 250
`define UES_SUSPEND_TIME_US 3000
`define UES_SUSPEND_CYCLES (`UES_SUSPEND_TIME_US * `UES_CLK_MHZ)
`define UES_CNT_W 24

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define UES_OFS_STATUS 8'h00
`define UES_OFS_MASK 8'h04
`define UES_OFS_CTRL 8'h08
`define UES_OFS_LINE 8'h0c

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define UES_EP_COUNT 3
`define UES_SRC_W 5
`define UES_SRC_SUSPEND 3
`define UES_SRC_RESUME 4
`define UES_CTRL_W 2
`define UES_CTRL_ENABLE 0
`define UES_CTRL_RSM_EN 1
`define UES_SRC_RESET 5'h00
`define UES_CTRL_RESET 2'h0

`endif

//--- logic/ues_pkg.sv
// Types shared by the usb event source block
`include "ues_params.svh"

package ues_pkg;

    typedef logic [`UES_CNT_W-1:0] ues_cnt_t;

    typedef enum logic [1:0] {
        LS_SE0,
        LS_J,
        LS_K,
        LS_SE1
    } ues_line_t;

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] sync3;
        ues_line_t line;
        ues_cnt_t cnt;
        logic fired;
        logic suspend_evt;
        logic resume_evt;
    } ues_mon_state_t;

    typedef struct packed {
        logic [`UES_SRC_W-1:0] status;
        logic [`UES_SRC_W-1:0] mask;
        logic [`UES_CTRL_W-1:0] ctrl;
        logic ack;
        logic [31:0] dat;
        logic irq;
    } ues_top_state_t;

endpackage : ues_pkg

//--- logic/ues_line_if.sv
// Carrier between register block and bus line monitor
`timescale 1ns/10ps
`default_nettype none

interface ues_line_if;
    import ues_pkg::*;
    logic usb_module_enable;
    logic resume_irq_enable;
    logic suspend_event;
    logic resume_event;
    ues_line_t line_state;

    modport mon (
        input usb_module_enable,
        input resume_irq_enable,
        output suspend_event,
        output resume_event,
        output line_state
    );

    modport ctl (
        output usb_module_enable,
        output resume_irq_enable,
        input suspend_event,
        input resume_event,
        input line_state
    );
endinterface : ues_line_if

`default_nettype wire

//--- logic/ues_line_mon.sv
// Bus line monitor: suspend and resume detection
`timescale 1ns/10ps
`default_nettype none
`include "ues_params.svh"

module ues_line_mon #(
    parameter int SUSPEND_CYCLES = `UES_SUSPEND_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic usb_line_plus_i,
    input wire logic usb_line_minus_i,
    ues_line_if.mon mon
);
    import ues_pkg::*;

    localparam ues_cnt_t SUSP_LAST = ues_cnt_t'(SUSPEND_CYCLES - 1);

    ues_mon_state_t s_reg;
    ues_mon_state_t s_next;
    ues_line_t cand;

    // ------------------------------------------------------------
    // Line decode of the agreed samples
    // ------------------------------------------------------------
    always_comb begin
        unique case (s_reg.sync3)
            2'b00: cand = LS_SE0;
            2'b10: cand = LS_J;
            2'b01: cand = LS_K;
            2'b11: cand = LS_SE1;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.sync1 = {usb_line_plus_i, usb_line_minus_i};
        s_next.sync2 = s_reg.sync1;
        s_next.sync3 = s_reg.sync2;
        s_next.suspend_evt = 1'b0;
        s_next.resume_evt = 1'b0;
        if (s_reg.sync2 == s_reg.sync3) begin
            s_next.line = cand;
        end
        // J to SE0 or K while both enables are set
        if (mon.usb_module_enable && mon.resume_irq_enable &&
            s_reg.line == LS_J &&
            (s_next.line == LS_SE0 || s_next.line == LS_K)) begin
            s_next.resume_evt = 1'b1;
        end
        // Idle J counting
        if (!mon.usb_module_enable || s_reg.line != LS_J) begin
            s_next.cnt = '0;
            s_next.fired = 1'b0;
        end else if (s_reg.cnt == SUSP_LAST) begin
            if (!s_reg.fired) begin
                s_next.suspend_evt = 1'b1;
                s_next.fired = 1'b1;
            end
        end else begin
            s_next.cnt = s_reg.cnt + ues_cnt_t'(1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s_reg <= '{sync1: 2'h0, sync2: 2'h0, sync3: 2'h0, line: LS_SE0,
                       cnt: '0, fired: 1'b0, suspend_evt: 1'b0,
                       resume_evt: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign mon.suspend_event = s_reg.suspend_evt;
    assign mon.resume_event = s_reg.resume_evt;
    assign mon.line_state = s_reg.line;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sus_after_idle: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        s_reg.suspend_evt |-> $past(s_reg.cnt) == SUSP_LAST &&
                              $past(s_reg.line) == LS_J)
        else $error("suspend event without full idle time");

    a_sus_needs_enable: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        s_reg.suspend_evt |-> $past(mon.usb_module_enable))
        else $error("suspend event while module disabled");

    a_rsm_from_j: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        s_reg.resume_evt |-> $past(s_reg.line) == LS_J &&
                             (s_reg.line == LS_SE0 || s_reg.line == LS_K))
        else $error("resume event without J to SE0 or K");

    a_rsm_needs_enables: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        s_reg.resume_evt |-> $past(mon.usb_module_enable) &&
                             $past(mon.resume_irq_enable))
        else $error("resume event while not enabled");

endmodule : ues_line_mon

`default_nettype wire

//--- logic/ues_top.sv
// USB device event sources with Wishbone register access
`timescale 1ns/10ps
`default_nettype none
`include "ues_params.svh"

module ues_top #(
    parameter int SUSPEND_CYCLES = `UES_SUSPEND_CYCLES,
    parameter int EP_COUNT = `UES_EP_COUNT
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [EP_COUNT-1:0] ep_buf0_ready_i,
    input wire logic [EP_COUNT-1:0] ep_buf1_ready_i,
    input wire logic [EP_COUNT-1:0] ep_xfer_err_i,
    input wire logic usb_line_plus_i,
    input wire logic usb_line_minus_i,
    output logic irq_o
);
    import ues_pkg::*;

    ues_top_state_t s_reg;
    ues_top_state_t s_next;
    logic [`UES_SRC_W-1:0] set_vec;
    logic [`UES_SRC_W-1:0] clr_vec;
    logic [EP_COUNT-1:0] ep_set;
    logic req;
    logic wr_take;

    ues_line_if line_if ();

    // ------------------------------------------------------------
    // Bus line monitor
    // ------------------------------------------------------------
    ues_line_mon #(
        .SUSPEND_CYCLES(SUSPEND_CYCLES)
    ) u_mon (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .usb_line_plus_i(usb_line_plus_i),
        .usb_line_minus_i(usb_line_minus_i),
        .mon(line_if.mon)
    );

    assign line_if.usb_module_enable = s_reg.ctrl[`UES_CTRL_ENABLE];
    assign line_if.resume_irq_enable = s_reg.ctrl[`UES_CTRL_RSM_EN];

    // ------------------------------------------------------------
    // Event collection
    // ------------------------------------------------------------
    for (genvar i = 0; i < EP_COUNT; i++) begin : g_ep
        // One bit per endpoint, buffers and error share it
        assign ep_set[i] = ep_buf0_ready_i[i] |
                           ep_buf1_ready_i[i] |
                           ep_xfer_err_i[i];

        a_ep_sets_bit: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            ep_set[i] |=> s_reg.status[i])
            else $error("endpoint event did not set its bit");

        a_ep_buf1_sets: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            ep_buf1_ready_i[i] ##1 !ep_set[i] |-> s_reg.status[i])
            else $error("buffer 1 ready bit not set");

        a_ep_buf0_sets: assert property (
            @(posedge core_clk_i) disable iff (rst_i)
            ep_buf0_ready_i[i] && !ep_buf1_ready_i[i] |=> s_reg.status[i])
            else $error("buffer 0 ready bit not set");
    end

    always_comb begin
        set_vec = '0;
        set_vec[EP_COUNT-1:0] = ep_set;
        set_vec[`UES_SRC_SUSPEND] = line_if.suspend_event;
        set_vec[`UES_SRC_RESUME] = line_if.resume_event;
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign req = wb_cyc_i && wb_stb_i;
    assign wr_take = req && wb_we_i && s_reg.ack && wb_sel_i[0];

    always_comb begin
        clr_vec = '0;
        if (wr_take && wb_adr_i == `UES_OFS_STATUS) begin
            clr_vec = wb_dat_i[`UES_SRC_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        // Set wins over a write-one clear
        s_next.status = (s_reg.status & ~clr_vec) | set_vec;
        s_next.ack = req && !s_reg.ack;
        if (wr_take && wb_adr_i == `UES_OFS_MASK) begin
            s_next.mask = wb_dat_i[`UES_SRC_W-1:0];
        end
        if (wr_take && wb_adr_i == `UES_OFS_CTRL) begin
            s_next.ctrl = wb_dat_i[`UES_CTRL_W-1:0];
        end
        if (req && !s_reg.ack) begin
            s_next.dat = 32'h0000_0000;
            unique case (wb_adr_i)
                `UES_OFS_STATUS: s_next.dat[`UES_SRC_W-1:0] = s_reg.status;
                `UES_OFS_MASK: s_next.dat[`UES_SRC_W-1:0] = s_reg.mask;
                `UES_OFS_CTRL: s_next.dat[`UES_CTRL_W-1:0] = s_reg.ctrl;
                `UES_OFS_LINE: s_next.dat[1:0] = line_if.line_state;
                default: s_next.dat = 32'h0000_0000;
            endcase
        end
        s_next.irq = |(s_reg.status & s_reg.mask);
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s_reg <= '{status: `UES_SRC_RESET, mask: `UES_SRC_RESET,
                       ctrl: `UES_CTRL_RESET, ack: 1'b0,
                       dat: 32'h0000_0000, irq: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_dat_o = s_reg.dat;
    assign wb_ack_o = s_reg.ack;
    assign irq_o = s_reg.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_status_sticky: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        s_reg.status[`UES_SRC_SUSPEND] && !clr_vec[`UES_SRC_SUSPEND]
        |=> s_reg.status[`UES_SRC_SUSPEND])
        else $error("suspend bit dropped without a clear");

    a_clear_loses_set: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        clr_vec[`UES_SRC_RESUME] && line_if.resume_event
        |=> s_reg.status[`UES_SRC_RESUME])
        else $error("resume event lost to a clear");

    a_sus_reaches_bit: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        line_if.suspend_event |=> s_reg.status[`UES_SRC_SUSPEND] ##1
        (irq_o || !$past(s_reg.mask[`UES_SRC_SUSPEND])))
        else $error("suspend event not reported");

endmodule : ues_top

`default_nettype wire

//--- test/ues_host_model.sv
// Host side model driving the two bus lines
`timescale 1ns/10ps
`default_nettype none

module ues_host_model (
    input wire ues_pkg::ues_line_t line_i,
    output logic usb_line_plus_o,
    output logic usb_line_minus_o
);
    import ues_pkg::*;
    // ----
    // Line levels per bus state
    // ----
    assign usb_line_plus_o = (line_i == LS_J) || (line_i == LS_SE1);
    assign usb_line_minus_o = (line_i == LS_K) || (line_i == LS_SE1);
endmodule : ues_host_model

`default_nettype wire

//--- test/ues_top_tb.sv
// Self-checking bench for the usb event source block
`timescale 1ns/10ps
`default_nettype none
`include "ues_params.svh"

module ues_top_tb;
    import ues_pkg::*;
    localparam int SC = 20;
    logic clk, rst, cyc, stb, we, ack, irq, lp, lm;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [3:0] sel;
    logic [2:0] b0, b1, er;
    ues_line_t line;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    int exp_sts = 0;
    int exp_msk = 0;

    ues_top #(.SUSPEND_CYCLES(SC), .EP_COUNT(3)) dut_u (
        .core_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ep_buf0_ready_i(b0),
        .ep_buf1_ready_i(b1), .ep_xfer_err_i(er), .usb_line_plus_i(lp),
        .usb_line_minus_i(lm), .irq_o(irq));

    ues_host_model host_u (.line_i(line), .usb_line_plus_o(lp),
        .usb_line_minus_o(lm));

    // ----
    // Checks and bus cycles
    // ----
    task automatic print_verdict;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t: reg %h exp %h", $time, g, e);
        end
    endtask : chk_reg

    task automatic chk_irq(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t: irq %b exp %b", $time, g, e);
        end
    endtask : chk_irq

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    task automatic wb(input logic w, input logic [7:0] a, input int d,
                      input logic [3:0] s = 4'hf);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= 32'(d);
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input int m, input int e);
        wb(1'b0, a, 0);
        chk_reg(q & 32'(m), 32'(e));
    endtask : rd

    task automatic pulse(input int k, input int ep);
        @(posedge clk);
        if (k == 0) b0 <= 3'(1 << ep);
        else if (k == 1) b1 <= 3'(1 << ep);
        else er <= 3'(1 << ep);
        @(posedge clk);
        b0 <= 3'h0;
        b1 <= 3'h0;
        er <= 3'h0;
        exp_sts |= 1 << ep;
    endtask : pulse

    // ----
    // Clock, timeout and stimulus
    // ----
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            errors++;
            $display("ERROR %0t: timeout", $time);
            print_verdict();
        end
    end

    initial begin
        rst = 1'b1;
        {cyc, stb, we, adr, wdat, sel} = '0;
        {b0, b1, er} = '0;
        line = LS_J;
        void'($urandom(32'h86e984e2));
        wt(16);
        rst <= 1'b0;
        rd(`UES_OFS_STATUS, -1, 0);
        rd(`UES_OFS_CTRL, -1, 0);
        rd(8'h10, -1, 0);
        wb(1'b1, `UES_OFS_MASK, 31, 4'he);
        rd(`UES_OFS_MASK, -1, 0);
        for (int k = 0; k < 3; k++) begin
            for (int ep = 0; ep < 3; ep++) begin
                exp_msk = $urandom & 7;
                wb(1'b1, `UES_OFS_MASK, exp_msk);
                pulse(k, ep);
                wt(4);
                chk_irq(irq, |(exp_sts & exp_msk));
                rd(`UES_OFS_STATUS, 7, exp_sts);
                wb(1'b1, `UES_OFS_STATUS, exp_sts);
                exp_sts = 0;
                rd(`UES_OFS_STATUS, 7, 0);
                chk_irq(irq, 1'b0);
            end
        end
        wt(2 * SC);
        rd(`UES_OFS_STATUS, 8, 0);
        wb(1'b1, `UES_OFS_CTRL, 1);
        wt(SC - 8);
        rd(`UES_OFS_STATUS, 8, 0);
        wt(12);
        rd(`UES_OFS_STATUS, 8, 8);
        wb(1'b1, `UES_OFS_STATUS, 8);
        wt(2 * SC);
        rd(`UES_OFS_STATUS, 8, 0);
        line <= LS_K;
        wt(10);
        rd(`UES_OFS_STATUS, 16, 0);
        rd(`UES_OFS_LINE, 3, 2);
        wb(1'b1, `UES_OFS_MASK, 16);
        wb(1'b1, `UES_OFS_CTRL, 3);
        for (int i = 0; i < 2; i++) begin
            line <= LS_J;
            wt(8);
            line <= i ? LS_K : LS_SE0;
            wt(8);
            rd(`UES_OFS_STATUS, 16, 16);
            chk_irq(irq, 1'b1);
            wb(1'b1, `UES_OFS_STATUS, 16);
        end
        print_verdict();
    end
endmodule : ues_top_tb

`default_nettype wire
